/* core/ccp_pkg.sv */
// Shared constants and types of the capture, compare and PWM unit.
// Assumes a 32-bit Avalon-MM slave bus with byte addresses.
package ccp_pkg;

  localparam int CCP_TW = 16;

  localparam logic [4:0] CCP_OFF_CTRL   = 5'h00;
  localparam logic [4:0] CCP_OFF_TOP    = 5'h04;
  localparam logic [4:0] CCP_OFF_TRUN   = 5'h08;
  localparam logic [4:0] CCP_OFF_CCV    = 5'h0C;
  localparam logic [4:0] CCP_OFF_STATUS = 5'h10;
  localparam logic [4:0] CCP_OFF_MASK   = 5'h14;
  localparam logic [4:0] CCP_OFF_STATE  = 5'h18;

  localparam int CCP_ST_CMP   = 0;
  localparam int CCP_ST_CAP   = 1;
  localparam int CCP_ST_FAULT = 2;
  localparam int CCP_ST_W     = 3;

  localparam int CCP_CTRL_W  = 13;
  localparam int CCP_TOP_B_LSB = 16;

  localparam logic [CCP_CTRL_W-1:0] CCP_CTRL_RST = 13'h0000;
  localparam logic [31:0]           CCP_TOP_RST  = 32'hFFFFFFFF;
  localparam logic [1:0]            CCP_TRUN_RST = 2'h0;
  localparam logic [CCP_TW-1:0]     CCP_CCV_RST  = 16'h0000;
  localparam logic [CCP_ST_W-1:0]   CCP_ST_RST   = 3'h0;

  localparam int CCP_DIV4  = 4;
  localparam int CCP_DIV16 = 16;
  localparam logic [3:0] CCP_PRE4_LAST  = 4'h3;
  localparam logic [3:0] CCP_PRE16_LAST = 4'hF;

  typedef enum logic [2:0] {
    CCP_MODE_OFF,
    CCP_MODE_CAPTURE,
    CCP_MODE_CMP_SET,
    CCP_MODE_CMP_TOGGLE,
    CCP_MODE_PWM_SINGLE,
    CCP_MODE_PWM_DUAL
  } ccp_mode_type;

  typedef enum logic [1:0] {
    CCP_EDGE_RISE,
    CCP_EDGE_FALL,
    CCP_EDGE_RISE4,
    CCP_EDGE_RISE16
  } ccp_edge_type;

  typedef struct packed {
    logic         evout_en;
    logic         dma_en;
    logic         cap_src;
    logic [1:0]   cap_per_irq;
    ccp_edge_type edge_sel;
    logic         init_level;
    ccp_mode_type mode;
    logic         tsel;
    logic         enable;
  } ccp_ctrl_type;

  typedef struct packed {
    logic             run;
    logic             dual;
    logic [CCP_TW-1:0] top;
  } ccp_tcfg_type;

endpackage

/* core/ccp_timer.sv */
// Free-running time base with single-slope or dual-slope counting.
// Assumes one clock domain; top of zero holds the count at zero.
`timescale 1ns/1ps
`default_nettype none
module ccp_timer (
  input  wire logic                      i_mclk,
  input  wire logic                      i_resetn,
  input  wire ccp_pkg::ccp_tcfg_type     i_cfg,
  output logic [ccp_pkg::CCP_TW-1:0]     o_count
);

  logic                       down;
  logic [ccp_pkg::CCP_TW-1:0] next_count;
  logic                       next_down;
  wire                        at_top  = (o_count >= i_cfg.top);
  wire                        at_zero = (o_count == '0);

  always_comb
  begin
    next_count = o_count;
    next_down  = down;
    if (i_cfg.run)
    begin
      if (!i_cfg.dual)
      begin
        next_down  = 1'b0;
        next_count = at_top ? '0 : o_count + 1'b1;
      end
      else if (i_cfg.top == '0)
      begin
        next_count = '0;
      end
      else if (down)
      begin
        next_down  = !at_zero;
        next_count = at_zero ? o_count + 1'b1 : o_count - 1'b1;
      end
      else
      begin
        next_down  = at_top;
        next_count = at_top ? o_count - 1'b1 : o_count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_count <= '0;
      down    <= 1'b0;
    end
    else
    begin
      o_count <= next_count;
      down    <= next_down;
    end
  end

endmodule // ccp_timer
`default_nettype wire

/* core/ccp_unit.sv */
// Capture, compare and PWM channel with two time bases and an Avalon-MM slave.
// Assumes pins and the routed event are synchronous to i_mclk.
// Behaviour
// R1 - Capture on rise, fall, 4th or 16th rise
// R2 - Channel picks one of two timers
// R3 - Software sets compare pin level before match
// R4 - Match sets active level or toggles pin
// R5 - Every compare match sets compare flag
// R6 - Counter compared with channel value every clock
// R7 - Match may request DMA, interrupt, event output
// R8 - Waveform mode: compare shapes period or width
// R9 - Period, width and routed event capture
// R10 - Captures per interrupt selectable by software
// R11 - Each channel drives exactly one pin
// R12 - Either fault input stops PWM pulses
// R13 - Single-slope: top is period, value duty
// R14 - Dual-slope counts up to top, down to zero
// R15 - Timer copied to capture register, then flag
// R16 - Reset: disabled, idle pin, flags clear
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ccp_unit (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_capture_input_pin,
  input  wire logic        i_capture_event,
  input  wire logic        i_fault_input_a,
  input  wire logic        i_fault_input_b,
  output logic             o_compare_output_pin,
  output logic             o_dma_req,
  output logic             o_event_out,
  output logic             o_irq
);

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  ccp_pkg::ccp_ctrl_type          ctrl;
  logic [31:0]                    tops;
  logic [1:0]                     trun;
  logic [ccp_pkg::CCP_TW-1:0]     ccv;
  logic [ccp_pkg::CCP_TW-1:0]     cap_reg;
  logic [ccp_pkg::CCP_ST_W-1:0]   status;
  logic [ccp_pkg::CCP_ST_W-1:0]   mask;
  logic                           ack;
  logic                           pin_q;
  logic                           evt_q;
  logic [3:0]                     pre_cnt;
  logic [1:0]                     cap_cnt;
  logic                           cap_done;
  logic [ccp_pkg::CCP_TW-1:0]     cnt_a;
  logic [ccp_pkg::CCP_TW-1:0]     cnt_b;
  logic                           next_pin;
  logic                           cmp_seen;

  // Every access gets one wait cycle, so read data can come from a flop
  wire acc     = (i_avs_read | i_avs_write) & ~ack;
  wire do_wr   = i_avs_write & ack;
  wire do_rd   = i_avs_read & ~ack;
  wire wr_ctrl = do_wr & (i_avs_address == ccp_pkg::CCP_OFF_CTRL);
  wire wr_top  = do_wr & (i_avs_address == ccp_pkg::CCP_OFF_TOP);
  wire wr_trun = do_wr & (i_avs_address == ccp_pkg::CCP_OFF_TRUN);
  wire wr_ccv  = do_wr & (i_avs_address == ccp_pkg::CCP_OFF_CCV);
  wire wr_st   = do_wr & (i_avs_address == ccp_pkg::CCP_OFF_STATUS);
  wire wr_mask = do_wr & (i_avs_address == ccp_pkg::CCP_OFF_MASK);
  wire [31:0] wdat = i_avs_writedata;

  assign o_avs_waitrequest = acc;

  // Two time bases; only the selected one follows the channel's slope mode
  wire dual_mode = ctrl.enable & (ctrl.mode == ccp_pkg::CCP_MODE_PWM_DUAL);
  ccp_pkg::ccp_tcfg_type cfg_a;
  ccp_pkg::ccp_tcfg_type cfg_b;
  assign cfg_a = '{run: trun[0], dual: dual_mode & ~ctrl.tsel, top: tops[ccp_pkg::CCP_TW-1:0]}; // R14
  assign cfg_b = '{run: trun[1], dual: dual_mode & ctrl.tsel,
                   top: tops[ccp_pkg::CCP_TOP_B_LSB +: ccp_pkg::CCP_TW]}; // R14

  ccp_timer u_timer_a (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_cfg    (cfg_a),
    .o_count  (cnt_a)
  );

  ccp_timer u_timer_b (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_cfg    (cfg_b),
    .o_count  (cnt_b)
  );

  wire [ccp_pkg::CCP_TW-1:0] tbase = ctrl.tsel ? cnt_b : cnt_a; // R2

  // Capture edge qualification
  wire is_cap   = ctrl.enable & (ctrl.mode == ccp_pkg::CCP_MODE_CAPTURE);
  wire src_now  = ctrl.cap_src ? i_capture_event : i_capture_input_pin; // R9
  wire src_prev = ctrl.cap_src ? evt_q : pin_q;
  wire rise     = src_now & ~src_prev;
  wire fall     = ~src_now & src_prev;
  wire pre_last = (ctrl.edge_sel == ccp_pkg::CCP_EDGE_RISE4) ? (pre_cnt[1:0] == ccp_pkg::CCP_PRE4_LAST[1:0])
                                                             : (pre_cnt == ccp_pkg::CCP_PRE16_LAST);
  wire cap_evt  = is_cap & ((ctrl.edge_sel == ccp_pkg::CCP_EDGE_RISE) ? rise :
                            (ctrl.edge_sel == ccp_pkg::CCP_EDGE_FALL) ? fall :
                            (rise & pre_last)); // R1
  wire cap_full = (cap_cnt == ctrl.cap_per_irq); // R10

  // Compare and waveform
  wire is_cmp   = ctrl.enable & ((ctrl.mode == ccp_pkg::CCP_MODE_CMP_SET) |
                                 (ctrl.mode == ccp_pkg::CCP_MODE_CMP_TOGGLE));
  wire is_pwm   = ctrl.enable & ((ctrl.mode == ccp_pkg::CCP_MODE_PWM_SINGLE) | dual_mode);
  wire match    = (is_cmp | is_pwm) & (tbase == ccv); // R6
  wire fault_in = is_pwm & (i_fault_input_a | i_fault_input_b);
  // Width set by value, period by the timer top
  wire pwm_lvl  = (tbase < ccv) ? ~ctrl.init_level : ctrl.init_level; // R8 R13

  always_comb
  begin
    next_pin = o_compare_output_pin;
    if (!(is_cmp | is_pwm))
      next_pin = ctrl.init_level; // R3
    else if (is_pwm)
      next_pin = (status[ccp_pkg::CCP_ST_FAULT] | fault_in) ? ctrl.init_level : pwm_lvl; // R12
    else if (match)
      next_pin = (ctrl.mode == ccp_pkg::CCP_MODE_CMP_TOGGLE) ? ~o_compare_output_pin
                                                               : ~ctrl.init_level; // R4
    else if (!cmp_seen)
      next_pin = ctrl.init_level; // R3
  end

  // Set wins over a write-one clear in the same cycle
  wire [ccp_pkg::CCP_ST_W-1:0] st_set = {fault_in, cap_done, match}; // R5
  wire [ccp_pkg::CCP_ST_W-1:0] st_clr = wr_st ? wdat[ccp_pkg::CCP_ST_W-1:0] : '0;

  wire [31:0] rd_mux =
    (i_avs_address == ccp_pkg::CCP_OFF_CTRL)   ? {19'h00000, ctrl} :
    (i_avs_address == ccp_pkg::CCP_OFF_TOP)    ? tops :
    (i_avs_address == ccp_pkg::CCP_OFF_TRUN)   ? {30'h00000000, trun} :
    (i_avs_address == ccp_pkg::CCP_OFF_CCV)    ? {cap_reg, ccv} :
    (i_avs_address == ccp_pkg::CCP_OFF_STATUS) ? {29'h00000000, status} :
    (i_avs_address == ccp_pkg::CCP_OFF_MASK)   ? {29'h00000000, mask} :
    (i_avs_address == ccp_pkg::CCP_OFF_STATE)  ? {tbase, 13'h0000, cap_cnt, o_compare_output_pin} :
    32'h00000000;

  wire [31:0] ctrl_w = be_merge({19'h00000, ctrl}, wdat, i_avs_byteenable);
  wire [31:0] ccv_w  = be_merge({16'h0000, ccv}, wdat, i_avs_byteenable);

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      ack            <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      ack <= acc;
      if (do_rd)
        o_avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      ctrl <= ccp_pkg::CCP_CTRL_RST; // R16
      tops <= ccp_pkg::CCP_TOP_RST;
      trun <= ccp_pkg::CCP_TRUN_RST;
      ccv  <= ccp_pkg::CCP_CCV_RST;
      mask <= ccp_pkg::CCP_ST_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= ccp_pkg::ccp_ctrl_type'(ctrl_w[ccp_pkg::CCP_CTRL_W-1:0]);
      if (wr_top)
        tops <= be_merge(tops, wdat, i_avs_byteenable);
      if (wr_trun & i_avs_byteenable[0])
        trun <= wdat[1:0];
      if (wr_ccv)
        ccv <= ccv_w[ccp_pkg::CCP_TW-1:0];
      if (wr_mask & i_avs_byteenable[0])
        mask <= wdat[ccp_pkg::CCP_ST_W-1:0];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      status               <= ccp_pkg::CCP_ST_RST; // R16
      pin_q                <= 1'b0;
      evt_q                <= 1'b0;
      pre_cnt              <= 4'h0;
      cap_cnt              <= 2'h0;
      cap_done             <= 1'b0;
      cmp_seen             <= 1'b0;
      cap_reg              <= '0;
      o_compare_output_pin <= 1'b0; // R16
      o_dma_req            <= 1'b0;
      o_event_out          <= 1'b0;
    end
    else
    begin
      status               <= (status & ~st_clr) | st_set;
      pin_q                <= i_capture_input_pin;
      evt_q                <= i_capture_event;
      o_compare_output_pin <= next_pin; // R11
      o_dma_req            <= match & ctrl.dma_en; // R7
      o_event_out          <= match & ctrl.evout_en; // R7
      cap_done             <= cap_evt & cap_full; // R15
      // Pin keeps its initial level until the first match of a compare run
      cmp_seen             <= is_cmp & (cmp_seen | match); // R3
      if (!is_cap)
      begin
        pre_cnt <= 4'h0;
        cap_cnt <= 2'h0;
      end
      else
      begin
        if (rise)
          pre_cnt <= pre_cnt + 4'h1;
        if (cap_evt)
        begin
          cap_reg <= tbase; // R15 R9
          cap_cnt <= cap_full ? 2'h0 : cap_cnt + 2'h1; // R10
        end
      end
    end
  end

  assign o_irq = |(status & mask); // R7

  a_cmp_flag_set: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R5
    match |=> status[ccp_pkg::CCP_ST_CMP]) else $error("compare match did not set flag");

  a_cap_copy: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R15
    cap_evt |=> (cap_reg == $past(tbase))) else $error("capture register missed timer value");

  a_cap_flag_after: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R10
    (cap_evt & cap_full) |=> cap_done ##1 status[ccp_pkg::CCP_ST_CAP])
    else $error("capture flag not raised after count");

  a_toggle_pin: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R4
    (match & is_cmp & (ctrl.mode == ccp_pkg::CCP_MODE_CMP_TOGGLE))
    |=> (o_compare_output_pin != $past(o_compare_output_pin))) else $error("toggle on match failed");

  a_idle_level: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R3
    !(is_cmp | is_pwm) |=> (o_compare_output_pin == $past(ctrl.init_level)))
    else $error("pin not at initial level");

  a_fault_stop: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R12
    fault_in |=> (o_compare_output_pin == $past(ctrl.init_level)) && status[ccp_pkg::CCP_ST_FAULT])
    else $error("fault did not stop pulses");

  a_dma_event: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R7
    $rose(o_dma_req) |-> $past(match) && $past(ctrl.dma_en)) else $error("stray dma request");

  a_pwm_duty: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R13
    (is_pwm & ~fault_in & ~status[ccp_pkg::CCP_ST_FAULT] & (tbase < ccv))
    |=> (o_compare_output_pin == ~$past(ctrl.init_level))) else $error("pwm duty level wrong");

  a_four_rises: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R1
    (cap_evt & (ctrl.edge_sel == ccp_pkg::CCP_EDGE_RISE4)) |-> (pre_cnt[1:0] == 2'h3))
    else $error("divide by four capture misplaced");

  a_bus_answer: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  a_wait_single: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait cycle");

  a_init_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R3
    (is_cmp & ~cmp_seen & ~match) |=> (o_compare_output_pin == $past(ctrl.init_level)))
    else $error("compare pin left initial level early");

  a_set_level: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R4
    (match & is_cmp & (ctrl.mode == ccp_pkg::CCP_MODE_CMP_SET))
    |=> (o_compare_output_pin == ~$past(ctrl.init_level))) else $error("set on match failed");

  a_event_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R7
    (match & ctrl.evout_en) |=> o_event_out)
    else $error("event output missing after match");

  a_dma_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R7
    (match & ctrl.dma_en) |=> o_dma_req)
    else $error("dma request missing after match");

  a_timer_wrap: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R13
    (cfg_a.run & ~cfg_a.dual & (cnt_a >= cfg_a.top)) |=> (cnt_a == '0))
    else $error("single slope timer did not wrap at top");

  a_dual_turn: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R14
    (cfg_b.run & cfg_b.dual & (cnt_b == cfg_b.top) & (cfg_b.top != '0)) |=> (cnt_b == $past(cnt_b) - 1'b1))
    else $error("dual slope timer did not turn at top");

  a_fault_latch: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R12
    (is_pwm & status[ccp_pkg::CCP_ST_FAULT]) |=> (o_compare_output_pin == $past(ctrl.init_level)))
    else $error("latched fault let pulses through");

  a_cap_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R15
    ~cap_evt |=> (cap_reg == $past(cap_reg)))
    else $error("capture register changed without event");

  a_mode_exit: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R10
    ~is_cap |=> ((cap_cnt == 2'h0) && (pre_cnt == 4'h0)))
    else $error("capture counters not cleared outside capture");

  a_reset_idle: assert property (@(posedge i_mclk) // R16
    ~i_resetn |=> ((status == '0) && ~o_compare_output_pin && ~o_dma_req && ~o_event_out))
    else $error("outputs not idle after reset");

  a_rise16: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R1
    (cap_evt & (ctrl.edge_sel == ccp_pkg::CCP_EDGE_RISE16)) |-> (pre_cnt == 4'hF))
    else $error("divide by sixteen capture misplaced");

  a_fall_edge: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R1
    (cap_evt & (ctrl.edge_sel == ccp_pkg::CCP_EDGE_FALL)) |-> (src_prev & ~src_now))
    else $error("falling edge capture without fall");

  a_flag_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R5
    (wr_st & wdat[ccp_pkg::CCP_ST_CMP] & ~match) |=> ~status[ccp_pkg::CCP_ST_CMP])
    else $error("compare flag not cleared by write");

endmodule // ccp_unit
`default_nettype wire

/* tb/ccp_pin_model.sv */
// Far-side model: capture pin, routed event line and fault lines.
// Assumes the bench issues one pulse request at a time.
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_model (
  input  wire logic       i_mclk,
  input  wire logic       i_start,
  input  wire logic       i_sel_evt,
  input  wire logic [3:0] i_width,
  input  wire logic [1:0] i_fault,
  output logic            o_pin,
  output logic            o_evt,
  output logic [1:0]      o_fault,
  output logic            o_busy
);
  logic [3:0] left = 4'h0;
  initial
  begin
    o_pin   = 1'b0;
    o_evt   = 1'b0;
    o_fault = 2'h0;
    o_busy  = 1'b0;
  end
  // One pulse gives one rise and one fall
  always @(posedge i_mclk)
  begin
    o_fault <= i_fault;
    if (i_start)
    begin
      left   <= i_width;
      o_busy <= 1'b1;
      if (i_sel_evt)
        o_evt <= 1'b1;
      else
        o_pin <= 1'b1;
    end
    else if (left != 4'h0)
      left <= left - 4'h1;
    else
    begin
      o_pin  <= 1'b0;
      o_evt  <= 1'b0;
      o_busy <= 1'b0;
    end
  end
endmodule // ccp_pin_model
`default_nettype wire

/* tb/ccp_unit_tb.sv */
// Self-checking bench of the capture, compare and PWM unit.
// Assumes an Avalon-MM slave; the master waits for waitrequest low.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if (32'(g) !== 32'(e)) begin n_fail++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, 32'(e), 32'(g)); end end
module ccp_unit_tb;
  logic i_mclk = 1'b0, i_resetn = 1'b0, rd = 1'b0, we = 1'b0, st = 1'b0, sev = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, q, seed = 32'h0000001F;
  logic [3:0] wid = 4'h0;
  logic [1:0] flt = 2'h0, fl;
  logic pin, evt, busy, cpin, dma, evo, irq, wt;
  logic [31:0] rdata;
  int n_fail = 0, checked = 0, k, h, e_pin;
  int cap_n[$] = {2, 1, 4, 16, 1};
  always #4 i_mclk = ~i_mclk;
  ccp_unit ccp_unit_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_capture_input_pin(pin),
    .i_capture_event(evt), .i_fault_input_a(fl[0]), .i_fault_input_b(fl[1]),
    .o_compare_output_pin(cpin), .o_dma_req(dma), .o_event_out(evo), .o_irq(irq));
  ccp_pin_model ccp_pin_model_i (.i_mclk(i_mclk), .i_start(st), .i_sel_evt(sev),
    .i_width(wid), .i_fault(flt), .o_pin(pin), .o_evt(evt), .o_fault(fl), .o_busy(busy));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    adr <= a;
    wd  <= d;
    we  <= w;
    rd  <= !w;
    do
      @(posedge i_mclk);
    while (wt !== 1'b0);
    q = rdata;
    we <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("readdata", e, q)
  endtask
  task automatic rst();
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_resetn <= 1'b1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic pulse(input logic ev);
    @(posedge i_mclk);
    st  <= 1'b1;
    sev <= ev;
    wid <= 4'(xs() % 16);
    @(posedge i_mclk);
    st <= 1'b0;
    do
      @(posedge i_mclk);
    while (busy !== 1'b0);
    cyc(4 + xs() % 4);
  endtask
  task automatic hi20();
    h = 0;
    repeat (20)
    begin
      @(negedge i_mclk);
      h += (cpin === 1'b1);
    end
  endtask
  task end_of_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge i_mclk);
    n_fail++;
    end_of_test;
  end
  initial
  begin
    rst();
    for (int i = 0; i < 8; i++)
      rdc(5'(i * 4), (i == 1) ? ccp_pkg::CCP_TOP_RST : 32'h0);
    wr(5'h1C, 32'hFFFFFFFF);
    rdc(5'h1C, 32'h0);
    `CHK("pin_rst", 0, cpin)
    `CHK("irq_rst", 0, irq)
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      rst();
      wr(ccp_pkg::CCP_OFF_TOP, 32'h14);
      wr(ccp_pkg::CCP_OFF_CCV, 1 + xs() % 19);
      wr(ccp_pkg::CCP_OFF_CTRL, 32'h1801 | ((m < 2 ? 2 : 3) << 2) | (m % 2) << 5);
      wr(ccp_pkg::CCP_OFF_MASK, 32'h1);
      cyc(2);
      `CHK("pin_init", m % 2, cpin)
      wr(ccp_pkg::CCP_OFF_TRUN, 32'h1);
      e_pin = m % 2;
      for (int n = 0; n < 2; n++)
      begin
        for (k = 0; k < 100 && dma !== 1'b1; k++)
          @(negedge i_mclk);
        e_pin = (m < 2) ? 1 - m % 2 : 1 - e_pin;
        `CHK("dma", 1, dma)
        `CHK("pin", e_pin, cpin)
        `CHK("event", 1, evo)
        `CHK("irq", 1, irq)
        cyc(1);
        `CHK("dma_end", 0, dma)
      end
      rdc(ccp_pkg::CCP_OFF_STATUS, 32'h1);
      wr(ccp_pkg::CCP_OFF_STATUS, 32'h1);
      rdc(ccp_pkg::CCP_OFF_STATUS, 32'h0);
      `CHK("irq_clr", 0, irq)
    end
    $display("test compare done");
    for (int c = 0; c < 5; c++)
    begin
      rst();
      wr(ccp_pkg::CCP_OFF_CTRL, 32'h5 | (c % 4) << 6 | (c == 0) << 8 | (c == 4) << 10);
      wr(ccp_pkg::CCP_OFF_MASK, 32'h2);
      for (int n = 1; n <= cap_n[c]; n++)
      begin
        pulse(c == 4);
        `CHK("cap_irq", n == cap_n[c], irq)
      end
      rdc(ccp_pkg::CCP_OFF_STATUS, 32'h2);
    end
    $display("test capture done");
    rst();
    wr(ccp_pkg::CCP_OFF_TOP, 32'h9);
    wr(ccp_pkg::CCP_OFF_CCV, 32'h5);
    wr(ccp_pkg::CCP_OFF_CTRL, 32'h11);
    wr(ccp_pkg::CCP_OFF_MASK, 32'h4);
    wr(ccp_pkg::CCP_OFF_TRUN, 32'h1);
    cyc(3);
    hi20();
    `CHK("pwm_duty", 10, h)
    @(posedge i_mclk);
    flt <= 2'(1 << (xs() % 2));
    cyc(3);
    `CHK("fault_irq", 1, irq)
    hi20();
    `CHK("fault_hold", 0, h)
    @(posedge i_mclk);
    flt <= 2'h0;
    cyc(3);
    hi20();
    `CHK("fault_latch", 0, h)
    wr(ccp_pkg::CCP_OFF_STATUS, 32'h4);
    cyc(3);
    hi20();
    `CHK("pwm_resume", 10, h)
    $display("test pwm done");
    rst();
    wr(ccp_pkg::CCP_OFF_TOP, 32'h000A0000);
    wr(ccp_pkg::CCP_OFF_CCV, 32'h5);
    wr(ccp_pkg::CCP_OFF_CTRL, 32'h17);
    wr(ccp_pkg::CCP_OFF_TRUN, 32'h2);
    cyc(3);
    hi20();
    `CHK("dual_duty", 2 * 5 - 1, h)
    $display("test dual pwm done");
    end_of_test;
  end
endmodule // ccp_unit_tb
`default_nettype wire
